// *** inc/sram_port_pkg.sv ***
package sram_port_pkg;
    // Array geometry
    localparam int ADDR_W = 18;
    localparam int DATA_W = 18;
    localparam int HALF_W = 9;
    localparam int WORDS = 262144;
    // Low half occupies bits 8:0, high half bits 17:9
    localparam int LO_POS = 0;
    localparam int HI_POS = 9;
    // Impedance settle time after power-up, in clock cycles
    localparam int IMP_SETTLE_CYCLES = 1024;
    localparam int IMP_CNT_W = 11;

    // One sampled command from the controller
    typedef struct packed {
        logic select_n;
        logic write_enable_n;
        logic byte_lo_write_n;
        logic byte_hi_write_n;
        logic [ADDR_W-1:0] addr;
    } cmd_t;

    typedef enum logic [1:0] {
        OP_IDLE,
        OP_READ,
        OP_WRITE
    } op_t;
endpackage

// *** test/ctrl_model.sv ***
// Far-side controller: every pin moves 1 ns after a rising edge
module ctrl_model (
    input wire logic clk_sys,
    output sram_port_pkg::cmd_t cmd,
    output logic [17:0] data_in,
    output logic out_enable_n,
    output logic sleep_req,
    output logic protocol_sel_1,
    output logic protocol_sel_2
);
    timeunit 1ns;
    timeprecision 1ps;
    // Straps are fixed from time zero and never move
    assign protocol_sel_1 = 1'b0;
    assign protocol_sel_2 = 1'b1;
    initial begin
        cmd = '{1'b1, 1'b1, 1'b1, 1'b1, 18'h00000};
        data_in = 18'h00000;
        out_enable_n = 1'b0;
        sleep_req = 1'b0;
    end
    // Levels only; the block resynchronises them
    task automatic set_async(input logic oe_n, input logic slp);
        out_enable_n = oe_n;
        sleep_req = slp;
    endtask
    // One command per cycle: 0 idle, 1 read, 2 write; ignored fields get noise
    task automatic issue(input int kind, input logic [17:0] ad, input logic [1:0] hn, input logic [17:0] wd);
        @(posedge clk_sys);
        #1;
        cmd.select_n = (kind == 0);
        cmd.write_enable_n = (kind == 2) ? 1'b0 : (kind == 1) ? 1'b1 : 1'($urandom);
        {cmd.byte_hi_write_n, cmd.byte_lo_write_n} = (kind == 2) ? hn : 2'($urandom);
        cmd.addr = (kind == 0) ? 18'($urandom) : ad;
        // Late data one cycle after the command cycle; else toggled so stale data never matches
        fork
            begin
                @(posedge clk_sys);
                #1;
                data_in = (kind == 2) ? wd : ~data_in;
            end
        join_none
    endtask
endmodule

// *** test/sync_late_write_sram_port_tb.sv ***
module sync_late_write_sram_port_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys, reset, oe_n, slp, sel1, sel2, data_oe, low_power, impedance_ready, protocol_bad;
    logic [17:0] data_in, data_out;
    logic [17:0] mem [logic [17:0]];
    logic [17:0] expq [$];
    logic [17:0] addrs [8];
    logic [1:0] hn_tab [3] = '{2'b10, 2'b01, 2'b00};
    sram_port_pkg::cmd_t cmd;
    int fails = 0, comparisons = 0, cycles = 0;
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    ctrl_model u_ctrl_model (.clk_sys(clk_sys), .cmd(cmd), .data_in(data_in), .out_enable_n(oe_n),
        .sleep_req(slp), .protocol_sel_1(sel1), .protocol_sel_2(sel2));
    sync_late_write_sram_port u_sync_late_write_sram_port (.clk_sys(clk_sys), .reset(reset),
        .select_n(cmd.select_n), .write_enable_n(cmd.write_enable_n), .byte_lo_write_n(cmd.byte_lo_write_n),
        .byte_hi_write_n(cmd.byte_hi_write_n), .addr_in(cmd.addr), .out_enable_n(oe_n), .sleep_req(slp),
        .protocol_sel_1(sel1), .protocol_sel_2(sel2), .data_in(data_in), .data_out(data_out),
        .data_oe(data_oe), .low_power(low_power), .impedance_ready(impedance_ready), .protocol_bad(protocol_bad));
    task automatic check(input string name, input logic [17:0] seen, input logic [17:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // Reference copy merges only the enabled halves
    task automatic wr(input logic [17:0] ad, input logic [1:0] hn, input logic [17:0] wd);
        logic [17:0] old;
        old = mem.exists(ad) ? mem[ad] : 18'h00000;
        if (!hn[0]) old[8:0] = wd[8:0];
        if (!hn[1]) old[17:9] = wd[17:9];
        mem[ad] = old;
        u_ctrl_model.issue(2, ad, hn, wd);
    endtask
    task automatic rd(input logic [17:0] ad, input bit shown);
        if (shown) expq.push_back(mem[ad]);
        u_ctrl_model.issue(1, ad, 2'b11, 18'h00000);
    endtask
    task automatic idle(input int n);
        repeat (n) u_ctrl_model.issue(0, 18'h00000, 2'b11, 18'h00000);
    endtask
    // Each driven word must be the oldest outstanding read; a drive with none pending fails
    always @(posedge clk_sys) begin
        #2;
        cycles++;
        if (cycles > 3000) begin
            fails++;
            tally_and_finish();
        end else if (data_oe === 1'b1) begin
            check("data_out", data_out, (expq.size() > 0) ? expq.pop_front() : 18'hxxxxx);
        end
    end
    initial begin
        void'($urandom(82476));
        reset = 1'b1;
        repeat (10) @(posedge clk_sys);
        #1 reset = 1'b0;
        idle(1000);
        check("impedance_ready", impedance_ready, 1'b0);
        check("protocol_bad", protocol_bad, 1'b0);
        idle(30);
        check("impedance_ready", impedance_ready, 1'b1);
        // Boundary and random addresses; every write is read back in the very next cycle
        foreach (addrs[i]) begin
            addrs[i] = (i == 0) ? 18'h00000 : (i == 1) ? 18'h3ffff : 18'($urandom);
            wr(addrs[i], 2'b00, 18'($urandom));
            rd(addrs[i], 1'b1);
            for (int m = 0; m < 3; m++) begin
                wr(addrs[i], hn_tab[m], 18'($urandom));
                rd(addrs[i], 1'b1);
            end
        end
        // Deselected cycles with noisy fields must leave contents intact
        idle(6);
        foreach (addrs[i]) rd(addrs[i], 1'b1);
        // Output enable high turns reads into dummy reads
        u_ctrl_model.set_async(1'b1, 1'b0);
        idle(3);
        rd(addrs[1], 1'b0);
        rd(addrs[2], 1'b0);
        idle(4);
        u_ctrl_model.set_async(1'b0, 1'b0);
        idle(3);
        rd(addrs[1], 1'b1);
        // Sleep blocks both the write and the read
        u_ctrl_model.set_async(1'b0, 1'b1);
        idle(4);
        check("low_power", low_power, 1'b1);
        u_ctrl_model.issue(2, addrs[2], 2'b00, ~mem[addrs[2]]);
        rd(addrs[2], 1'b0);
        idle(4);
        u_ctrl_model.set_async(1'b0, 1'b0);
        idle(4);
        check("low_power", low_power, 1'b0);
        rd(addrs[2], 1'b1);
        idle(6);
        check("pending reads", 18'(expq.size()), 18'h00000);
        tally_and_finish();
    end
endmodule

// *** verilog/sram_array.sv ***
// Word memory with per-half write enables and registered read data
module sram_array #(
    parameter int ADDR_W = 18,
    parameter int HALF_W = 9,
    parameter int WORDS = 262144
) (
    input wire logic clk_sys,
    input wire logic wr_en,
    input wire logic [1:0] wr_half,
    input wire logic [ADDR_W-1:0] wr_addr,
    input wire logic [2*HALF_W-1:0] wr_data,
    input wire logic rd_en,
    input wire logic [ADDR_W-1:0] rd_addr,
    output logic [2*HALF_W-1:0] rd_data
);
    logic [2*HALF_W-1:0] mem [WORDS];

    // Each half has its own write strobe
    genvar h;
    generate
        for (h = 0; h < 2; h++) begin : g_half
            always_ff @(posedge clk_sys) begin
                if (wr_en && wr_half[h]) begin
                    mem[wr_addr][h*HALF_W +: HALF_W] <= wr_data[h*HALF_W +: HALF_W];
                end
            end
        end
    endgenerate

    // Read data held in a register, old contents on a same-address write
    always_ff @(posedge clk_sys) begin
        if (rd_en) begin
            rd_data <= mem[rd_addr];
        end
    end
endmodule

// *** verilog/sync_late_write_sram_port.sv ***
// Operation
// - Stores 262144 words of 18 bits, addressed by 18 registered address bits.
// - Select, write enable, byte enables and address are sampled each rising clock.
// - Two active-low byte enables each gate one 9-bit half of a write.
// - Write data arrives the cycle after the command; outputs float in the cycle the data edge opens.
// - Selected read with output enable low drives the word the next cycle.
// - Sleep high forces low power and floats all data pins, sampled through two clocked flops.
// - Output enable high floats the data pins; a read becomes a dummy read.
// - Works from the true clock edge of the single-ended clk_sys.
// - Don't-care inputs are ignored whatever their value.
// - Write or deselect floats outputs and refreshes impedance; 1024 cycles to settle.
module sync_late_write_sram_port (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic select_n,
    input wire logic write_enable_n,
    input wire logic byte_lo_write_n,
    input wire logic byte_hi_write_n,
    input wire logic [sram_port_pkg::ADDR_W-1:0] addr_in,
    input wire logic out_enable_n,
    input wire logic sleep_req,
    input wire logic protocol_sel_1,
    input wire logic protocol_sel_2,
    input wire logic [sram_port_pkg::DATA_W-1:0] data_in,
    output logic [sram_port_pkg::DATA_W-1:0] data_out,
    output logic data_oe,
    output logic low_power,
    output logic impedance_ready,
    output logic protocol_bad
);
    // Asynchronous pins pass two flops before use
    logic oe_meta_q, oe_n_q, sleep_meta_q, sleep_q;
    logic [1:0] psel_meta_q, psel_q;
    always_ff @(posedge clk_sys) begin
        oe_meta_q <= out_enable_n;
        oe_n_q <= oe_meta_q;
        sleep_meta_q <= sleep_req;
        sleep_q <= sleep_meta_q;
        psel_meta_q <= {protocol_sel_2, protocol_sel_1};
        psel_q <= psel_meta_q;
    end

    // Command register: every command pin sampled on the true clock edge
    sram_port_pkg::cmd_t cmd_q;
    always_ff @(posedge clk_sys) begin
        cmd_q <= '{select_n, write_enable_n, byte_lo_write_n, byte_hi_write_n, addr_in};
    end

    // One decode serves the raw pins and the command register, so both agree on what a read is
    function automatic sram_port_pkg::op_t decode_op(
        input logic blocked,
        input logic sel_n,
        input logic we_n
    );
        if (blocked || sel_n) begin
            return sram_port_pkg::OP_IDLE;
        end
        if (!we_n) begin
            return sram_port_pkg::OP_WRITE;
        end
        return sram_port_pkg::OP_READ;
    endfunction

    // Decode of the sampled command; sleep and reset block all operations
    sram_port_pkg::op_t op;
    sram_port_pkg::op_t pin_op;
    assign op = decode_op(sleep_q || reset, cmd_q.select_n, cmd_q.write_enable_n);
    assign pin_op = decode_op(1'b0, select_n, write_enable_n);
    wire is_write = (op == sram_port_pkg::OP_WRITE);
    wire is_read = (op == sram_port_pkg::OP_READ);
    wire pin_read = (pin_op == sram_port_pkg::OP_READ);
    wire [1:0] halves = {~cmd_q.byte_hi_write_n, ~cmd_q.byte_lo_write_n};

    // Late write: the command edge opens the cycle and its data is taken at the very next edge,
    // so the write works from the command register and needs no pending stage
    wire commit = is_write;

    // Storage; the array captures the read address from the pins at the command edge,
    // which leaves exactly one cycle to reach the output register
    logic [sram_port_pkg::DATA_W-1:0] arr_q;
    sram_array #(
        .ADDR_W(sram_port_pkg::ADDR_W),
        .HALF_W(sram_port_pkg::HALF_W),
        .WORDS(sram_port_pkg::WORDS)
    ) u_array (
        .clk_sys(clk_sys),
        .wr_en(commit),
        .wr_half(halves),
        .wr_addr(cmd_q.addr),
        .wr_data(data_in),
        .rd_en(pin_read),
        .rd_addr(addr_in),
        .rd_data(arr_q)
    );

    // Forwarding: a read taken at the edge where the previous write commits sees the old word,
    // so the written halves are captured beside it and merged on the way out
    logic fwd_q;
    logic [1:0] fwd_half_q;
    logic [sram_port_pkg::DATA_W-1:0] fwd_data_q;
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            fwd_q <= 1'b0;
            fwd_half_q <= 2'h0;
            fwd_data_q <= '0;
        end else begin
            fwd_q <= pin_read && commit && (cmd_q.addr == addr_in);
            fwd_half_q <= halves;
            fwd_data_q <= data_in;
        end
    end

    // Merge array word with forwarded halves
    logic [sram_port_pkg::DATA_W-1:0] rd_word;
    genvar h;
    generate
        for (h = 0; h < 2; h++) begin : g_merge
            assign rd_word[h*sram_port_pkg::HALF_W +: sram_port_pkg::HALF_W] =
                (fwd_q && fwd_half_q[h]) ? fwd_data_q[h*sram_port_pkg::HALF_W +: sram_port_pkg::HALF_W]
                                         : arr_q[h*sram_port_pkg::HALF_W +: sram_port_pkg::HALF_W];
        end
    endgenerate

    // Drive in the cycle after the read's command edge, only with output enable low and awake
    wire drive = is_read && !oe_n_q && !sleep_q;
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            data_out <= '0;
            data_oe <= 1'b0;
        end else begin
            data_oe <= drive;
            data_out <= drive ? rd_word : data_out;
        end
    end

    // Impedance refresh: counts only while outputs float, settles after 1024 cycles
    logic [sram_port_pkg::IMP_CNT_W-1:0] imp_cnt_q;
    wire imp_done = (imp_cnt_q == sram_port_pkg::IMP_CNT_W'(sram_port_pkg::IMP_SETTLE_CYCLES));
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            imp_cnt_q <= '0;
            impedance_ready <= 1'b0;
        end else begin
            if (!data_oe && !imp_done) begin
                imp_cnt_q <= imp_cnt_q + 1'b1;
            end
            impedance_ready <= imp_done;
        end
    end

    // Low-power flag and protocol strap check (strap must read low, high)
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            low_power <= 1'b0;
            protocol_bad <= 1'b0;
        end else begin
            low_power <= sleep_q;
            protocol_bad <= (psel_q != 2'h2);
        end
    end

    // Checks: output drive and float rules
    wire oe_pair = !oe_n_q && !sleep_q;
    read_drive_a: assert property (@(posedge clk_sys) disable iff (reset)
        is_read && oe_pair |=> data_oe) else $error("read not driven");
    write_float_a: assert property (@(posedge clk_sys) disable iff (reset)
        is_write |=> !data_oe) else $error("driven in write cycle");
    deselect_float_a: assert property (@(posedge clk_sys) disable iff (reset)
        op == sram_port_pkg::OP_IDLE |=> !data_oe) else $error("driven after deselect");
    sleep_float_a: assert property (@(posedge clk_sys) disable iff (reset)
        sleep_q |=> !data_oe && low_power) else $error("pins driven in sleep");
    oe_float_a: assert property (@(posedge clk_sys) disable iff (reset)
        oe_n_q |=> !data_oe) else $error("driven with output enable high");

    // Write path: the enabled halves must sit in the array right after the data edge
    late_commit_a: assert property (@(posedge clk_sys) disable iff (reset)
        commit |=> (!$past(halves[0])
            || u_array.mem[$past(cmd_q.addr)][sram_port_pkg::LO_POS +: sram_port_pkg::HALF_W]
            == $past(data_in[sram_port_pkg::LO_POS +: sram_port_pkg::HALF_W]))
        && (!$past(halves[1])
            || u_array.mem[$past(cmd_q.addr)][sram_port_pkg::HI_POS +: sram_port_pkg::HALF_W]
            == $past(data_in[sram_port_pkg::HI_POS +: sram_port_pkg::HALF_W])))
        else $error("late write lost");

    // Forwarding: a read right behind a write sees the new word, captured halves only
    forward_a: assert property (@(posedge clk_sys) disable iff (reset)
        commit && pin_read && addr_in == cmd_q.addr && halves == 2'h3 ##1 is_read && oe_pair
        |=> data_out == $past(data_in, 2)) else $error("forwarded data wrong");
    forward_capture_a: assert property (@(posedge clk_sys) disable iff (reset)
        commit && pin_read && addr_in == cmd_q.addr |=> fwd_q && fwd_half_q == $past(halves))
        else $error("forward not captured");
    no_forward_a: assert property (@(posedge clk_sys) disable iff (reset)
        !commit |=> !fwd_q) else $error("forward without a write");

    // Status outputs
    imp_settle_a: assert property (@(posedge clk_sys) disable iff (reset)
        impedance_ready |-> imp_cnt_q == sram_port_pkg::IMP_CNT_W'(sram_port_pkg::IMP_SETTLE_CYCLES))
        else $error("impedance ready too early");
    imp_hold_a: assert property (@(posedge clk_sys) disable iff (reset)
        data_oe |=> imp_cnt_q == $past(imp_cnt_q)) else $error("impedance counted while driving");
    strap_a: assert property (@(posedge clk_sys) disable iff (reset)
        psel_q == 2'h2 |=> !protocol_bad) else $error("strap flagged wrongly");
    strap_bad_a: assert property (@(posedge clk_sys) disable iff (reset)
        psel_q != 2'h2 |=> protocol_bad) else $error("bad strap not flagged");
    low_wake_a: assert property (@(posedge clk_sys) disable iff (reset)
        !sleep_q |=> !low_power) else $error("low power flag stuck");
    reset_quiet_a: assert property (@(posedge clk_sys)
        reset |=> !data_oe && !low_power && !impedance_ready && !protocol_bad)
        else $error("outputs not cleared by reset");

    // Main scenarios
    read_c: cover property (@(posedge clk_sys) disable iff (reset) is_read ##1 data_oe);
    write_c: cover property (@(posedge clk_sys) disable iff (reset) is_write ##1 is_read);
    fwd_c: cover property (@(posedge clk_sys) disable iff (reset) fwd_q);
    sleep_c: cover property (@(posedge clk_sys) disable iff (reset) low_power);
    dummy_c: cover property (@(posedge clk_sys) disable iff (reset) is_read && oe_n_q);
endmodule
